// file: rtl/pact_cycle_timer.sv
// isochronous cycle timer counters with 24.576 MHz tick divider
`timescale 1ns/1ps
`default_nettype none
module pact_cycle_timer (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // configuration
  input  wire logic                 run,
  input  wire logic                 ext_src,
  input  wire logic                 ext_tick,
  // load port
  input  wire logic                 load,
  input  wire pact_pkg::pact_timer_t load_val,
  // state
  output pact_pkg::pact_timer_t     value,
  output logic                      rollover
);
  import pact_pkg::*;

  logic [16:0] acc_reg;      // phase accumulator
  logic        tick_en_reg;  // one-cycle 24.576 MHz enable
  logic        ext_prev_reg; // last ext tick level for edge detect
  pact_timer_t tmr_reg;      // counter fields
  logic        roll_reg;     // rollover pulse

  // advance cycle_number, carrying into second_count
  function automatic pact_timer_t next_cycle(input pact_timer_t t);
    pact_timer_t r;
    r = t;
    r.tick_offset = '0;
    if (t.cycle_number >= PACT_CYC_LAST) begin
      r.cycle_number = '0;
      r.second_count = t.second_count + 7'h01;
    end else begin
      r.cycle_number = t.cycle_number + 13'h0001;
    end
    return r;
  endfunction

  // fractional divider; it stops with run so no stale tick slips out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg     <= '0;
      tick_en_reg <= 1'b0;
    end else if (run) begin
      if (acc_reg + PACT_ACC_STEP >= PACT_ACC_MOD) begin
        acc_reg     <= acc_reg + PACT_ACC_STEP - PACT_ACC_MOD;
        tick_en_reg <= 1'b1;
      end else begin
        acc_reg     <= acc_reg + PACT_ACC_STEP;
        tick_en_reg <= 1'b0;
      end
    end else begin
      tick_en_reg <= 1'b0;
    end
  end

  // external tick edge; input is already synchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ext_prev_reg <= 1'b0;
    else        ext_prev_reg <= ext_tick;
  end

  // counters: load beats external tick beats normal count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_reg  <= '0;
      roll_reg <= 1'b0;
    end else if (load) begin
      tmr_reg  <= load_val;
      roll_reg <= 1'b0;
    end else if (ext_src && ext_tick && !ext_prev_reg) begin
      tmr_reg  <= next_cycle(tmr_reg);
      roll_reg <= 1'b1;
    end else if (run && tick_en_reg) begin
      if (tmr_reg.tick_offset >= PACT_OFS_LAST) begin
        if (ext_src) begin
          roll_reg <= 1'b0; // wait for the external tick, hold at end
        end else begin
          tmr_reg  <= next_cycle(tmr_reg);
          roll_reg <= 1'b1;
        end
      end else begin
        tmr_reg.tick_offset <= tmr_reg.tick_offset + 12'h001;
        roll_reg            <= 1'b0;
      end
    end else begin
      roll_reg <= 1'b0;
    end
  end

  assign value    = tmr_reg;
  assign rollover = roll_reg;

endmodule // pact_cycle_timer
`default_nettype wire

// file: rtl/pact_top.sv
// phy register access port and isochronous cycle timer register bank
//
// How it works
// - request write clears read complete flag
// - phy register transfer sets read complete
// - reserved phy access bits read zero
// - read index follows latest phy transfer
// - read value holds phy returned contents
// - read request sent, then bit self-clears
// - write request sent, then bit self-clears
// - target index addresses phy for both
// - write value sent on writes only
// - cycle master sends timer in cycle start
// - non-master loads timer from received start
// - timer keeps counting without cycle starts
// - seconds count cycle rollovers modulo 128
// - cycles count offset rollovers modulo 8000
// - offset counts ticks modulo 3072
// - external 8 kHz tick zeroes offset
// - root master emits start per rollover
// - offset advances only while run set
`timescale 1ns/1ps
`default_nettype none
module pact_top (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // register port
  input  wire pact_pkg::pact_bus_req_t bus_req,
  output logic [31:0]                 bus_rdata,
  // request towards the phy
  output logic                        phy_req_valid,
  output pact_pkg::pact_phy_req_t     phy_req,
  input  wire logic                   phy_req_ready,
  // register transfer from the phy
  input  wire logic                   phy_rsp_valid,
  input  wire pact_pkg::pact_phy_rsp_t phy_rsp,
  input  wire logic                   phy_is_root,
  // cycle start traffic
  input  wire logic                   cs_rx_valid,
  input  wire pact_pkg::pact_timer_t  cs_rx_time,
  output logic                        cs_tx_valid,
  output pact_pkg::pact_timer_t       cs_tx_time,
  // external 8 kHz cycle clock
  input  wire logic                   ext_cycle_tick
);
  import pact_pkg::*;

  // link control state
  logic            master_sel_reg;  // timing_master_select
  logic            run_reg;         // tick_count_run
  logic            ext_src_reg;     // external cycle source enable

  // phy access register state
  logic            rd_done_reg;     // phy_read_complete
  logic [3:0]      rd_index_reg;    // phy_read_index
  logic [7:0]      rd_value_reg;    // phy_read_value
  logic            rd_req_reg;      // phy_read_request
  logic            wr_req_reg;      // phy_write_request
  logic [3:0]      tgt_index_reg;   // phy_target_index
  logic [7:0]      wr_value_reg;    // phy_write_value

  // phy request sequencer
  pact_phy_state_t phy_state_reg;
  pact_phy_state_t phy_state_next;
  logic            phy_valid_reg;   // drives phy_req_valid
  pact_phy_req_t   phy_req_reg;     // drives phy_req
  logic            sent;            // phy accepted the request

  // bus decode
  logic            wr_ctrl;         // write to link control
  logic            wr_pa;           // write to phy access
  logic            wr_tmr;          // write to cycle timer
  logic [31:0]     rdata_reg;       // registered read data
  logic [31:0]     rd_mux;          // combinational read select

  // cycle timer
  pact_timer_t     tmr_value;       // live counter value
  logic            tmr_roll;        // one-cycle rollover
  logic            tmr_load;        // load request to counters
  pact_timer_t     tmr_load_val;    // value to load
  logic            master_active;   // we own the cycle start
  logic            cs_valid_reg;    // drives cs_tx_valid
  pact_timer_t     cs_time_reg;     // drives cs_tx_time

  // address decode, one register per aligned word
  always_comb begin
    wr_ctrl = bus_req.wr && (bus_req.addr == PACT_OFF_LINK_CTRL);
    wr_pa   = bus_req.wr && (bus_req.addr == PACT_OFF_PHY_ACCESS);
    wr_tmr  = bus_req.wr && (bus_req.addr == PACT_OFF_CYCLE_TIMER);
  end

  // link control bits; root status comes live from the phy side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_sel_reg <= 1'b0;
      run_reg        <= 1'b0;
      ext_src_reg    <= 1'b0;
    end else if (wr_ctrl) begin
      master_sel_reg <= bus_req.wdata[PACT_CTRL_MASTER_BIT];
      run_reg        <= bus_req.wdata[PACT_CTRL_RUN_BIT];
      ext_src_reg    <= bus_req.wdata[PACT_CTRL_EXT_BIT];
    end
  end

  // target index and write value are plain read/write fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_index_reg <= '0;
      wr_value_reg  <= '0;
    end else if (wr_pa) begin
      tgt_index_reg <= bus_req.wdata[PACT_PA_TIDX_LO +: 4];
      wr_value_reg  <= bus_req.wdata[PACT_PA_WVAL_LO +: 8];
    end
  end

  // read complete: cleared by a new request, set by phy transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_done_reg <= 1'b0;
    end else if (phy_rsp_valid) begin
      rd_done_reg <= 1'b1; // set wins over a same-cycle clear
    end else if (wr_pa && (bus_req.wdata[PACT_PA_RDREQ_BIT] ||
                           bus_req.wdata[PACT_PA_WRREQ_BIT])) begin
      rd_done_reg <= 1'b0;
    end
  end

  // returned index and contents from the phy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_index_reg <= '0;
      rd_value_reg <= '0;
    end else if (phy_rsp_valid) begin
      rd_index_reg <= phy_rsp.index;
      rd_value_reg <= phy_rsp.value;
    end
  end

  // accepted handshake ends the request on the phy side
  assign sent = phy_valid_reg && phy_req_ready;

  // request bits: software sets, hardware clears once sent;
  // writing 0 never cancels a request already on its way
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_req_reg <= 1'b0;
      wr_req_reg <= 1'b0;
    end else begin
      if (wr_pa && bus_req.wdata[PACT_PA_RDREQ_BIT]) begin
        rd_req_reg <= 1'b1;
      end else if (sent && !phy_req_reg.write) begin
        rd_req_reg <= 1'b0;
      end
      if (wr_pa && bus_req.wdata[PACT_PA_WRREQ_BIT]) begin
        wr_req_reg <= 1'b1;
      end else if (sent && phy_req_reg.write) begin
        wr_req_reg <= 1'b0;
      end
    end
  end

  // sequencer next state
  always_comb begin
    phy_state_next = phy_state_reg;
    unique case (phy_state_reg)
      PACT_PHY_IDLE: begin
        if (rd_req_reg || wr_req_reg) phy_state_next = PACT_PHY_SEND;
      end
      PACT_PHY_SEND: begin
        if (sent) phy_state_next = PACT_PHY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) phy_state_reg <= PACT_PHY_IDLE;
    else        phy_state_reg <= phy_state_next;
  end

  // request payload is frozen while offered so the phy sees it stable;
  // read wins if software breaks exclusivity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_valid_reg <= 1'b0;
      phy_req_reg   <= '0;
    end else if (phy_state_reg == PACT_PHY_IDLE) begin
      if (rd_req_reg || wr_req_reg) begin
        phy_valid_reg     <= 1'b1;
        phy_req_reg.write <= !rd_req_reg;
        phy_req_reg.index <= tgt_index_reg;
        // data field carries nothing on reads
        phy_req_reg.value <= rd_req_reg ? 8'h00 : wr_value_reg;
      end
    end else if (sent) begin
      phy_valid_reg <= 1'b0;
    end
  end

  assign phy_req_valid = phy_valid_reg;
  assign phy_req       = phy_req_reg;

  // master owns cycle start only when the phy says we are root
  assign master_active = master_sel_reg && phy_is_root;

  // software write beats a received cycle start in the same cycle
  always_comb begin
    tmr_load     = 1'b0;
    tmr_load_val = cs_rx_time;
    if (wr_tmr) begin
      tmr_load     = 1'b1;
      tmr_load_val = pact_timer_t'(bus_req.wdata);
    end else if (cs_rx_valid && !master_sel_reg) begin
      tmr_load = 1'b1;
    end
  end

  // counters and tick divider
  pact_cycle_timer i_pact_cycle_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (run_reg),
    .ext_src  (ext_src_reg),
    .ext_tick (ext_cycle_tick),
    .load     (tmr_load),
    .load_val (tmr_load_val),
    .value    (tmr_value),
    .rollover (tmr_roll)
  );

  // cycle start out: timer value at each rollover while master
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_valid_reg <= 1'b0;
      cs_time_reg  <= '0;
    end else begin
      cs_valid_reg <= master_active && tmr_roll;
      if (master_active && tmr_roll) begin
        cs_time_reg <= tmr_value;
      end
    end
  end

  assign cs_tx_valid = cs_valid_reg;
  assign cs_tx_time  = cs_time_reg;

  // read select; unmapped offsets read zero
  always_comb begin
    rd_mux = PACT_ZERO_WORD;
    unique case (bus_req.addr)
      PACT_OFF_LINK_CTRL: begin
        rd_mux[PACT_CTRL_ROOT_BIT]   = phy_is_root;
        rd_mux[PACT_CTRL_MASTER_BIT] = master_sel_reg;
        rd_mux[PACT_CTRL_RUN_BIT]    = run_reg;
        rd_mux[PACT_CTRL_EXT_BIT]    = ext_src_reg;
      end
      PACT_OFF_PHY_ACCESS: begin
        // bits 30:28 and 13:12 stay at zero
        rd_mux[PACT_PA_DONE_BIT]        = rd_done_reg;
        rd_mux[PACT_PA_RIDX_LO +: 4]    = rd_index_reg;
        rd_mux[PACT_PA_RVAL_LO +: 8]    = rd_value_reg;
        rd_mux[PACT_PA_RDREQ_BIT]       = rd_req_reg;
        rd_mux[PACT_PA_WRREQ_BIT]       = wr_req_reg;
        rd_mux[PACT_PA_TIDX_LO +: 4]    = tgt_index_reg;
        rd_mux[PACT_PA_WVAL_LO +: 8]    = wr_value_reg;
      end
      PACT_OFF_CYCLE_TIMER: begin
        rd_mux = tmr_value;
      end
      default: begin
        rd_mux = PACT_ZERO_WORD;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)          rdata_reg <= PACT_ZERO_WORD;
    else if (bus_req.rd) rdata_reg <= rd_mux;
    else                 rdata_reg <= PACT_ZERO_WORD;
  end

  assign bus_rdata = rdata_reg;

endmodule // pact_top
`default_nettype wire

// file: shared/pact_pkg.sv
// shared constants, types and register map of the phy access / cycle timer
package pact_pkg;

  // register map: byte offsets on the 8-bit address of the 32-bit register port
  localparam logic [7:0] PACT_OFF_LINK_CTRL   = 8'he0;
  localparam logic [7:0] PACT_OFF_PHY_ACCESS  = 8'hec;
  localparam logic [7:0] PACT_OFF_CYCLE_TIMER = 8'hf0;

  // link control bits
  localparam int unsigned PACT_CTRL_ROOT_BIT   = 30; // read-only root status
  localparam int unsigned PACT_CTRL_MASTER_BIT = 21; // timing_master_select
  localparam int unsigned PACT_CTRL_RUN_BIT    = 20; // tick_count_run
  localparam int unsigned PACT_CTRL_EXT_BIT    = 0;  // external 8 kHz source

  // phy access register fields
  localparam int unsigned PACT_PA_DONE_BIT  = 31;
  localparam int unsigned PACT_PA_RIDX_LO   = 24;
  localparam int unsigned PACT_PA_RVAL_LO   = 16;
  localparam int unsigned PACT_PA_RDREQ_BIT = 15;
  localparam int unsigned PACT_PA_WRREQ_BIT = 14;
  localparam int unsigned PACT_PA_TIDX_LO   = 8;
  localparam int unsigned PACT_PA_WVAL_LO   = 0;

  // reset values
  localparam logic [31:0] PACT_ZERO_WORD = 32'h0000_0000;

  // cycle timer moduli
  localparam logic [12:0] PACT_CYC_LAST = 13'h1f3f; // 8000 - 1
  localparam logic [11:0] PACT_OFS_LAST = 12'hbff;  // 3072 - 1

  // tick rate: 24.576 MHz made from the 100 MHz clock by a phase accumulator
  localparam int unsigned PACT_SYS_CLK_KHZ = 100000;
  localparam int unsigned PACT_TICK_KHZ    = 24576;
  localparam logic [16:0] PACT_ACC_STEP    = 17'(PACT_TICK_KHZ);
  localparam logic [16:0] PACT_ACC_MOD     = 17'(PACT_SYS_CLK_KHZ);

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pact_bus_req_t;

  // request towards the phy
  typedef struct packed {
    logic       write;
    logic [3:0] index;
    logic [7:0] value;
  } pact_phy_req_t;

  // register transfer coming back from the phy
  typedef struct packed {
    logic [3:0] index;
    logic [7:0] value;
  } pact_phy_rsp_t;

  // cycle timer word, packed in register layout
  typedef struct packed {
    logic [6:0]  second_count;
    logic [12:0] cycle_number;
    logic [11:0] tick_offset;
  } pact_timer_t;

  // phy request sequencer
  typedef enum logic {
    PACT_PHY_IDLE,
    PACT_PHY_SEND
  } pact_phy_state_t;

endpackage

// file: tb/pact_assertions.sv
// port-level checks bound onto the phy access and cycle timer block
`timescale 1ns/1ps
`default_nettype none
module pact_assertions (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // register port
  input wire pact_pkg::pact_bus_req_t bus_req,
  input wire logic [31:0]             bus_rdata,
  // phy side
  input wire logic                    phy_req_valid,
  input wire pact_pkg::pact_phy_req_t phy_req,
  input wire logic                    phy_req_ready,
  input wire logic                    phy_rsp_valid,
  input wire pact_pkg::pact_phy_rsp_t phy_rsp,
  input wire logic                    phy_is_root,
  // cycle start traffic and external tick
  input wire logic                    cs_rx_valid,
  input wire pact_pkg::pact_timer_t   cs_rx_time,
  input wire logic                    cs_tx_valid,
  input wire pact_pkg::pact_timer_t   cs_tx_time,
  input wire logic                    ext_cycle_tick
);
  import pact_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pa_rd; // read strobe on the phy access word
  logic pa_rq; // write that sets a request bit
  // decode the strobes once, the four register-port checks share them
  assign pa_rd = bus_req.rd && bus_req.addr == PACT_OFF_PHY_ACCESS;
  assign pa_rq = bus_req.wr && bus_req.addr == PACT_OFF_PHY_ACCESS
                 && (bus_req.wdata[15] || bus_req.wdata[14]);
  AST_DONE_CLR: assert property (
    pa_rq && !phy_rsp_valid ##1 pa_rd |=> !bus_rdata[31])
    else $error("read complete flag not cleared");
  AST_RSP_CAP: assert property (
    phy_rsp_valid ##1 pa_rd
    |=> bus_rdata[31:16] == {1'b1, 3'h0, $past(phy_rsp, 2)})
    else $error("phy transfer not captured");
  AST_RSV_ZERO: assert property (
    pa_rd |=> bus_rdata[30:28] == 3'h0 && bus_rdata[13:12] == 2'h0)
    else $error("reserved bits not zero");
  AST_REQ_GO: assert property (
    pa_rq && !phy_req_valid |-> ##2 phy_req_valid)
    else $error("phy request not issued");
  AST_REQ_HOLD: assert property (
    phy_req_valid && !phy_req_ready |=> phy_req_valid && $stable(phy_req))
    else $error("phy request moved before acceptance");
  AST_REQ_DROP: assert property (
    phy_req_valid && phy_req_ready |=> !phy_req_valid)
    else $error("phy request held after acceptance");
  AST_RD_NOVAL: assert property (
    phy_req_valid && !phy_req.write |-> phy_req.value == 8'h00)
    else $error("read request carries write value");
  AST_TX_ZERO: assert property (
    cs_tx_valid |-> cs_tx_time.tick_offset == 12'h000)
    else $error("cycle start offset not zero");
  AST_TX_ONE: assert property (
    cs_tx_valid |=> !cs_tx_valid [*8])
    else $error("cycle start not a single pulse");
  AST_TX_ROOT: assert property (
    !phy_is_root [*3] |-> !cs_tx_valid)
    else $error("cycle start sent while not root");
endmodule // pact_assertions
bind pact_top pact_assertions i_pact_assertions (.clk, .rst_n, .bus_req,
  .bus_rdata, .phy_req_valid, .phy_req, .phy_req_ready, .phy_rsp_valid,
  .phy_rsp, .phy_is_root, .cs_rx_valid, .cs_rx_time, .cs_tx_valid,
  .cs_tx_time, .ext_cycle_tick);
`default_nettype wire

// file: tb/pact_phy_model.sv
// behavioural phy: register file, request handshake, read answers
`timescale 1ns/1ps
`default_nettype none
module pact_phy_model (
  // clock, reset and pacing
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    slow,
  // request from the link
  input  wire logic                    phy_req_valid,
  input  wire pact_pkg::pact_phy_req_t phy_req,
  output logic                         phy_req_ready,
  // register transfer back to the link
  output logic                         phy_rsp_valid,
  output pact_pkg::pact_phy_rsp_t      phy_rsp
);
  import pact_pkg::*;
  logic [7:0] regs [16]; // phy register file
  logic [1:0] stall;     // wait count in slow mode
  logic [1:0] lat;       // read answer countdown
  logic [3:0] ridx;      // index being read
  // ready only after seeing valid; drops at the accepting edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_req_ready <= 1'b0;
      stall <= 2'h0;
    end else begin
      phy_req_ready <= phy_req_valid && !phy_req_ready
                       && (!slow || stall == 2'h3);
      stall <= (phy_req_valid && !phy_req_ready) ? stall + 2'h1 : 2'h0;
    end
  end
  // writes land at once; reads answer three cycles later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat <= 2'h0;
      ridx <= 4'h0;
      phy_rsp_valid <= 1'b0;
      phy_rsp <= '0;
    end else begin
      phy_rsp_valid <= lat == 2'h1;
      // idle data toggles so a stale value never looks valid
      phy_rsp <= (lat == 2'h1) ? {ridx, regs[ridx]} : ~phy_rsp;
      if (lat != 2'h0) lat <= lat - 2'h1;
      if (phy_req_valid && phy_req_ready) begin
        if (phy_req.write) regs[phy_req.index] <= phy_req.value;
        else begin
          lat <= 2'h3;
          ridx <= phy_req.index;
        end
      end
    end
  end
endmodule // pact_phy_model
`default_nettype wire

// file: tb/tb_phy_access_and_cycle_timer.sv
// self-checking bench for the phy access port and cycle timer
`timescale 1ns/1ps
`default_nettype none
module tb_phy_access_and_cycle_timer;
  import pact_pkg::*;
  // design-facing signals
  logic          clk;
  logic          rst_n;
  pact_bus_req_t bus_req;
  logic [31:0]   bus_rdata;
  logic          phy_req_valid;
  pact_phy_req_t phy_req;
  logic          phy_req_ready;
  logic          phy_rsp_valid;
  pact_phy_rsp_t phy_rsp;
  logic          phy_is_root;
  logic          cs_rx_valid;
  pact_timer_t   cs_rx_time;
  logic          cs_tx_valid;
  pact_timer_t   cs_tx_time;
  logic          ext_cycle_tick;
  logic          slow;       // phy model pacing
  // bookkeeping
  int            fail_count = 0;
  int            comparisons = 0;
  int            cycles = 0;
  logic [31:0]   rd;         // last read word
  logic          seen;       // cycle start observed
  localparam logic [31:0] RUN = 32'h0010_0000;
  localparam logic [31:0] MST = 32'h0020_0000;
  pact_top i_pact_top (.clk, .rst_n, .bus_req, .bus_rdata, .phy_req_valid,
    .phy_req, .phy_req_ready, .phy_rsp_valid, .phy_rsp, .phy_is_root,
    .cs_rx_valid, .cs_rx_time, .cs_tx_valid, .cs_tx_time, .ext_cycle_tick);
  pact_phy_model i_pact_phy_model (.clk, .rst_n, .slow, .phy_req_valid,
    .phy_req, .phy_req_ready, .phy_rsp_valid, .phy_rsp);
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes; settle one step after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 rd = bus_rdata;
  endtask
  // poll the phy access word until a bit settles, bounded
  task automatic wait_pa(input int b, input logic v);
    rdr(PACT_OFF_PHY_ACCESS);
    for (int i = 0; i < 60 && rd[b] !== v; i++) rdr(PACT_OFF_PHY_ACCESS);
    chk(32'(rd[b]), 32'(v));
  endtask
  task automatic send_rx(input logic [31:0] v);
    cs_rx_time <= v;
    cs_rx_valid <= 1'b1;
    @(posedge clk);
    cs_rx_valid <= 1'b0;
    cs_rx_time <= ~v;
    #1;
  endtask
  task automatic wait_tx();
    seen = 1'b0;
    repeat (100) begin
      @(posedge clk);
      #1 seen |= (cs_tx_valid === 1'b1);
    end
  endtask
  task automatic t_reset();
    logic [7:0] al [4] = '{PACT_OFF_PHY_ACCESS, PACT_OFF_LINK_CTRL,
                           PACT_OFF_CYCLE_TIMER, 8'h44};
    foreach (al[i]) begin
      rdr(al[i]);
      chk(rd, PACT_ZERO_WORD);
    end
    $display("test reset done");
  endtask
  task automatic t_phy();
    slow <= 1'b1;
    wr(PACT_OFF_PHY_ACCESS, 32'h0000_45a5);
    wait_pa(14, 1'b0);
    chk(32'(i_pact_phy_model.regs[5]), 32'h0000_00a5);
    slow <= 1'b0;
    wr(PACT_OFF_PHY_ACCESS, 32'h7000_b5ff);
    wait_pa(31, 1'b1);
    chk(rd, 32'h85a5_05ff);
    wr(PACT_OFF_PHY_ACCESS, 32'h0000_4e3c);
    rdr(PACT_OFF_PHY_ACCESS);
    chk(32'(rd[31]), 32'h0);
    wait_pa(14, 1'b0);
    chk(32'(i_pact_phy_model.regs[14]), 32'h0000_003c);
    $display("test phy access done");
  endtask
  task automatic t_wrap();
    logic [31:0] held; // whole timer word read just after the stop
    wr(PACT_OFF_LINK_CTRL, RUN);
    wr(PACT_OFF_CYCLE_TIMER, {7'h7f, 13'h1f3f, 12'hbfd});
    repeat (20) @(posedge clk);
    rdr(PACT_OFF_CYCLE_TIMER);
    chk(32'(rd[31:12]), 32'h0);
    chk(32'(rd[11:0] inside {[1:4]}), 32'h1);
    wr(PACT_OFF_LINK_CTRL, 32'h0);
    rdr(PACT_OFF_CYCLE_TIMER);
    held = rd;
    repeat (20) @(posedge clk);
    rdr(PACT_OFF_CYCLE_TIMER);
    chk(rd, held);
    chk(32'(rd[11:0] <= 12'h5), 32'h1);
    $display("test wrap done");
  endtask
  task automatic t_master();
    phy_is_root <= 1'b1;
    wr(PACT_OFF_LINK_CTRL, MST | RUN);
    wr(PACT_OFF_CYCLE_TIMER, {7'h12, 13'h0040, 12'hbf8});
    wait_tx();
    chk(32'(seen), 32'h1);
    chk(cs_tx_time, {7'h12, 13'h0041, 12'h000});
    send_rx(32'h0);
    rdr(PACT_OFF_CYCLE_TIMER);
    chk(32'(rd[24:12]), 32'h41);
    phy_is_root <= 1'b0;
    wr(PACT_OFF_CYCLE_TIMER, {7'h12, 13'h0050, 12'hbf8});
    wait_tx();
    chk(32'(seen), 32'h0);
    $display("test master done");
  endtask
  task automatic t_slave();
    wr(PACT_OFF_LINK_CTRL, 32'h0);
    send_rx(32'h2468_a5e0);
    rdr(PACT_OFF_CYCLE_TIMER);
    chk(rd, 32'h2468_a5e0);
    wr(PACT_OFF_LINK_CTRL, RUN);
    repeat (40) @(posedge clk);
    rdr(PACT_OFF_CYCLE_TIMER);
    chk(32'(rd[31:12]), 32'h2468a);
    chk(32'(rd[11:0] inside {[12'h5e1:12'h5f0]}), 32'h1);
    $display("test slave done");
  endtask
  task automatic t_ext();
    wr(PACT_OFF_LINK_CTRL, RUN | 32'h1);
    wr(PACT_OFF_CYCLE_TIMER, 32'h0000_5300);
    ext_cycle_tick <= 1'b1;
    repeat (4) @(posedge clk);
    ext_cycle_tick <= 1'b0;
    rdr(PACT_OFF_CYCLE_TIMER);
    chk(32'(rd[24:12]), 32'h6);
    chk(32'(rd[11:0] < 12'h4), 32'h1);
    $display("test external tick done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    phy_is_root = 1'b0;
    cs_rx_valid = 1'b0;
    cs_rx_time = '0;
    ext_cycle_tick = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_phy();
    t_wrap();
    t_master();
    t_slave();
    t_ext();
    summarize();
  end
endmodule // tb_phy_access_and_cycle_timer
`default_nettype wire
